/* File: scd_pkg.sv */
// package: register map, field layout and timing constants for settle and divider logic
package scd_pkg;
  localparam logic [7:0]  SCD_ADDR_CH2_SETTLE = 8'h12;
  localparam logic [7:0]  SCD_ADDR_CH3_SETTLE = 8'h13;
  localparam logic [7:0]  SCD_ADDR_CH0_DIV    = 8'h14;
  localparam logic [7:0]  SCD_ADDR_CH1_DIV    = 8'h15;
  localparam logic [15:0] SCD_SETTLE_RESET    = 16'h0000;
  localparam logic [15:0] SCD_DIV_RESET       = 16'h0000;
  localparam int          SCD_REF_DIV_LSB     = 0;
  localparam int          SCD_REF_DIV_W       = 10;
  localparam int          SCD_RSVD_LSB        = 10;
  localparam int          SCD_IN_DIV_LSB      = 12;
  localparam int          SCD_IN_DIV_W        = 4;
  localparam logic [19:0] SCD_SETTLE_MIN_PER  = 20'h00020;
  localparam int          SCD_SETTLE_MULT_SH  = 4;
  localparam logic [15:0] SCD_SETTLE_SHORT_MAX = 16'h0001;
endpackage

/* File: scd_divider.sv */
// module: programmable divider producing a one-cycle tick every div input events
`timescale 1ns/10ps
module scd_divider #(
  parameter int W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         event_i,
  input  wire logic [W-1:0] div_i,
  output logic              tick_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_tick;

  // a divide of zero is reserved; it is treated as one so the tick never stalls
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (event_i) begin
      if (cnt + W'(1) >= div_i) begin
        next_cnt  = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule

/* File: scd_settle_div.sv */
// module: per-channel settle timers and reference/input clock dividers
//
// Behaviour
// - a settle interval runs on a channel before its conversion, length from its settle count.
// - counts 0 and 1 give 32 reference periods, larger counts give sixteen times the count.
// - if settle is still running when conversion starts, an amplitude error pulses if enabled.
// - each settle count is a 16-bit read-write field that resets to zero.
// - each reference tick is the master clock divided by its 10-bit reference divider.
// - the sensor input is divided by the 4-bit input divider in bits 15:12.
// - channel 2 and 3 settle registers sit at 0x12 and 0x13 on the four-channel variant.
`timescale 1ns/10ps
module scd_settle_div
  import scd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  output logic [15:0]      reg_rdata_o,
  input  wire logic [1:0]  settle_start_i,
  input  wire logic [1:0]  conv_start_i,
  input  wire logic        amp_err_en_i,
  input  wire logic [1:0]  sensor_edge_i,
  output logic [1:0]       ref_tick_o,
  output logic [1:0]       input_tick_o,
  output logic [1:0]       settle_done_o,
  output logic [1:0]       amp_err_o
);
  // channels 2,3 settle; channels 0,1 dividers
  typedef enum logic [2:0] {
    SCD_IDLE   = 3'b001,
    SCD_SETTLE = 3'b010,
    SCD_DONE   = 3'b100
  } scd_state_t;

  function automatic logic [19:0] settle_periods(input logic [15:0] cnt);
    if (cnt <= SCD_SETTLE_SHORT_MAX) begin
      settle_periods = SCD_SETTLE_MIN_PER;
    end else begin
      settle_periods = {4'h0, cnt} << SCD_SETTLE_MULT_SH;
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] channel2_settle_count;
  logic [15:0] channel3_settle_count;
  logic [15:0] channel0_clock_division;
  logic [15:0] channel1_clock_division;
  logic [15:0] next_s2, next_s3, next_d0, next_d1, next_rdata;

  always_comb begin
    next_s2 = channel2_settle_count;
    next_s3 = channel3_settle_count;
    next_d0 = channel0_clock_division;
    next_d1 = channel1_clock_division;
    if (reg_wr_i) begin
      case (reg_addr_i)
        SCD_ADDR_CH2_SETTLE: next_s2 = reg_wdata_i;
        SCD_ADDR_CH3_SETTLE: next_s3 = reg_wdata_i;
        SCD_ADDR_CH0_DIV:    next_d0 = reg_wdata_i;
        SCD_ADDR_CH1_DIV:    next_d1 = reg_wdata_i;
        default:             next_s2 = channel2_settle_count;
      endcase
    end
    case (reg_addr_i)
      SCD_ADDR_CH2_SETTLE: next_rdata = channel2_settle_count;
      SCD_ADDR_CH3_SETTLE: next_rdata = channel3_settle_count;
      SCD_ADDR_CH0_DIV:    next_rdata = channel0_clock_division;
      SCD_ADDR_CH1_DIV:    next_rdata = channel1_clock_division;
      default:             next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      channel2_settle_count   <= SCD_SETTLE_RESET;
      channel3_settle_count   <= SCD_SETTLE_RESET;
      channel0_clock_division <= SCD_DIV_RESET;
      channel1_clock_division <= SCD_DIV_RESET;
      reg_rdata_o             <= 16'h0000;
    end else begin
      channel2_settle_count   <= next_s2;
      channel3_settle_count   <= next_s3;
      channel0_clock_division <= next_d0;
      channel1_clock_division <= next_d1;
      reg_rdata_o             <= next_rdata;
    end
  end

  // ----------------------------------------
  // dividers
  // ----------------------------------------
  logic [SCD_REF_DIV_W-1:0] channel0_reference_div, channel1_reference_div;
  logic [SCD_IN_DIV_W-1:0]  channel0_sensor_input_div, channel1_sensor_input_div;
  assign channel0_reference_div    = channel0_clock_division[SCD_REF_DIV_LSB +: SCD_REF_DIV_W];
  assign channel1_reference_div    = channel1_clock_division[SCD_REF_DIV_LSB +: SCD_REF_DIV_W];
  assign channel0_sensor_input_div = channel0_clock_division[SCD_IN_DIV_LSB +: SCD_IN_DIV_W];
  assign channel1_sensor_input_div = channel1_clock_division[SCD_IN_DIV_LSB +: SCD_IN_DIV_W];

  scd_divider #(.W(SCD_REF_DIV_W)) u_ref0 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .event_i (1'b1),
    .div_i   (channel0_reference_div),
    .tick_o  (ref_tick_o[0])
  );
  scd_divider #(.W(SCD_REF_DIV_W)) u_ref1 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .event_i (1'b1),
    .div_i   (channel1_reference_div),
    .tick_o  (ref_tick_o[1])
  );
  scd_divider #(.W(SCD_IN_DIV_W)) u_in0 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .event_i (sensor_edge_i[0]),
    .div_i   (channel0_sensor_input_div),
    .tick_o  (input_tick_o[0])
  );
  scd_divider #(.W(SCD_IN_DIV_W)) u_in1 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .event_i (sensor_edge_i[1]),
    .div_i   (channel1_sensor_input_div),
    .tick_o  (input_tick_o[1])
  );

  // ----------------------------------------
  // settle timers (channels 2 and 3)
  // ----------------------------------------
  // no ref dividers for 2,3 here; they borrow channel 0/1 reference ticks
  scd_state_t  state [2];
  scd_state_t  next_state [2];
  logic [19:0] remain [2];
  logic [19:0] next_remain [2];
  logic [1:0]  next_done, next_err;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      next_state[c]  = state[c];
      next_remain[c] = remain[c];
      next_done[c]   = 1'b0;
      next_err[c]    = 1'b0;
      case (state[c])
        SCD_IDLE: begin
          if (settle_start_i[c]) begin
            next_state[c]  = SCD_SETTLE;
            next_remain[c] = settle_periods(c == 0 ? channel2_settle_count
                                                   : channel3_settle_count);
          end
        end
        SCD_SETTLE: begin
          if (conv_start_i[c]) begin
            next_state[c] = SCD_IDLE;
            next_err[c]   = amp_err_en_i;
          end else if (ref_tick_o[c]) begin
            next_remain[c] = remain[c] - 20'h00001;
            if (remain[c] == 20'h00001) begin
              next_state[c] = SCD_DONE;
              next_done[c]  = 1'b1;
            end
          end
        end
        SCD_DONE: begin
          if (conv_start_i[c]) begin
            next_state[c] = SCD_IDLE;
          end
        end
        default: next_state[c] = SCD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state[0]      <= SCD_IDLE;
      state[1]      <= SCD_IDLE;
      remain[0]     <= 20'h00000;
      remain[1]     <= 20'h00000;
      settle_done_o <= 2'h0;
      amp_err_o     <= 2'h0;
    end else begin
      state[0]      <= next_state[0];
      state[1]      <= next_state[1];
      remain[0]     <= next_remain[0];
      remain[1]     <= next_remain[1];
      settle_done_o <= next_done;
      amp_err_o     <= next_err;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence settle_begin_s;
    state[0] == SCD_IDLE && settle_start_i[0];
  endsequence

  settle_load_a : assert property (@(posedge clk_i) disable iff (reset_i)
    settle_begin_s |=> remain[0] == settle_periods($past(channel2_settle_count)))
    else $error("settle count loaded wrong");

  settle_enter_a : assert property (@(posedge clk_i) disable iff (reset_i)
    settle_begin_s |=> state[0] == SCD_SETTLE)
    else $error("settle did not start");

  amp_error_a : assert property (@(posedge clk_i) disable iff (reset_i)
    (state[0] == SCD_SETTLE && conv_start_i[0]) |=> amp_err_o[0] == $past(amp_err_en_i))
    else $error("amplitude error wrong");

  ch3_amp_error_a : assert property (@(posedge clk_i) disable iff (reset_i)
    (state[1] == SCD_SETTLE && conv_start_i[1]) |=> amp_err_o[1] == $past(amp_err_en_i))
    else $error("channel 3 amplitude error wrong");

  no_error_a : assert property (@(posedge clk_i) disable iff (reset_i)
    (state[0] != SCD_SETTLE) |=> !amp_err_o[0])
    else $error("spurious amplitude error");

  settle_done_a : assert property (@(posedge clk_i) disable iff (reset_i)
    (state[0] == SCD_SETTLE && !conv_start_i[0] && ref_tick_o[0] && remain[0] == 20'h00001)
      |=> settle_done_o[0] && state[0] == SCD_DONE)
    else $error("settle done missing");

  settle_write_a : assert property (@(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == SCD_ADDR_CH3_SETTLE) |=> channel3_settle_count == $past(reg_wdata_i))
    else $error("settle register write lost");

  read_back_a : assert property (@(posedge clk_i) disable iff (reset_i)
    (!reg_wr_i && reg_addr_i == SCD_ADDR_CH2_SETTLE) |=> reg_rdata_o == channel2_settle_count)
    else $error("settle register read wrong");

  ref_period_a : assert property (@(posedge clk_i) disable iff (reset_i)
    (ref_tick_o[0] && channel0_reference_div == 10'h002 && $stable(channel0_reference_div))
      |=> !ref_tick_o[0] ##1 ref_tick_o[0])
    else $error("reference divide by two wrong");
endmodule

/* File: scd_tank_model.sv */
// sensor tank model: one edge pulse per oscillation period on two channels
`timescale 1ns/10ps
module scd_tank_model #(
  parameter int PER0 = 5,
  parameter int PER1 = 7
) (
  input  wire logic       clk_i,
  input  wire logic [1:0] en_i,
  output logic [1:0]      edge_o
);
  int cnt[2] = '{0, 0};
  initial edge_o = 2'b00;
  // a stopped tank gives no edges at all
  always @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      cnt[c] = en_i[c] ? (cnt[c] + 1) % (c ? PER1 : PER0) : 0;
      edge_o[c] <= en_i[c] && cnt[c] == 0;
    end
  end
endmodule

/* File: tb_scd_settle_div.sv */
// bench for settle timers, dividers and their registers
`timescale 1ns/10ps
module tb_scd_settle_div;
  import scd_pkg::*;
  typedef struct {int k; logic [15:0] v;} scd_note_t;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i = 1'b0;
  logic [15:0] reg_rdata_o, d;
  logic [1:0]  settle_start_i = 2'b00;
  logic [1:0]  conv_start_i = 2'b00;
  logic        amp_err_en_i = 1'b0;
  logic [1:0]  sensor_edge_i, ref_tick_o, input_tick_o, settle_done_o, amp_err_o;
  logic        rd_chk = 1'b0;
  logic [9:0]  rdv;
  logic [3:0]  ndv;
  logic [15:0] cnt[4];
  int          miscompares = 0, n_tests = 0, cyc = 0;
  int          tk[2], lr[2], li[2], gr[2], gi[2];
  scd_note_t   q[$];

  scd_settle_div DUT (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
    .settle_start_i(settle_start_i), .conv_start_i(conv_start_i),
    .amp_err_en_i(amp_err_en_i), .sensor_edge_i(sensor_edge_i), .ref_tick_o(ref_tick_o),
    .input_tick_o(input_tick_o), .settle_done_o(settle_done_o), .amp_err_o(amp_err_o));
  scd_tank_model #(.PER0(5), .PER1(7)) tank (.clk_i(clk_i), .en_i(2'b11),
    .edge_o(sensor_edge_i));

  // ----------------------------
  // checking and bus tasks
  // ----------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (e !== s) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic take(int k, logic [15:0] s);
    scd_note_t n;
    if (q.size() == 0) begin
      miscompares++;
      $display("CHECK FAILED result %0d expected none seen %h", k, s);
    end else begin
      n = q.pop_front();
      chk("result kind", n.k[15:0], k[15:0]);
      chk("result value", n.v, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    q.push_back(scd_note_t'{0, e});
    reg_addr_i <= a;
    @(posedge clk_i);
    rd_chk <= 1'b1;
    @(posedge clk_i);
    rd_chk <= 1'b0;
  endtask
  task automatic settle(int c, logic [15:0] n);
    int i;
    wr(c ? SCD_ADDR_CH3_SETTLE : SCD_ADDR_CH2_SETTLE, n);
    q.push_back(scd_note_t'{1 + c, (n < 2) ? 16'h0020 : {n[11:0], 4'h0}});
    settle_start_i[c] <= 1'b1;
    @(posedge clk_i);
    settle_start_i[c] <= 1'b0;
    for (i = 0; i < 20000 && settle_done_o[c] !== 1'b1; i++) @(posedge clk_i);
    if (i == 20000) begin
      miscompares++;
      give_verdict();
    end
    // start after expiry must not count as early
    conv_start_i[c] <= 1'b1;
    @(posedge clk_i);
    conv_start_i[c] <= 1'b0;
  endtask
  task automatic abort(int c, logic en);
    amp_err_en_i <= en;
    settle_start_i[c] <= 1'b1;
    @(posedge clk_i);
    settle_start_i[c] <= 1'b0;
    repeat (3) @(posedge clk_i);
    if (en) q.push_back(scd_note_t'{3 + c, 16'h0001});
    conv_start_i[c] <= 1'b1;
    @(posedge clk_i);
    conv_start_i[c] <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("notes left", 16'h0000, 16'(q.size()));
  endtask

  // ----------------------------
  // monitor and stimulus
  // ----------------------------
  always @(posedge clk_i) begin
    cyc++;
    if (rd_chk) take(0, reg_rdata_o);
    for (int c = 0; c < 2; c++) begin
      if (amp_err_o[c]) take(3 + c, 16'h0001);
      if (settle_start_i[c]) tk[c] = 0;
      else if (settle_done_o[c]) take(1 + c, tk[c][15:0]);
      else if (ref_tick_o[c]) tk[c]++;
      if (ref_tick_o[c]) begin
        gr[c] = cyc - lr[c];
        lr[c] = cyc;
      end
      if (input_tick_o[c]) begin
        gi[c] = cyc - li[c];
        li[c] = cyc;
      end
    end
  end
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    void'($urandom(32'hCFB1));
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(SCD_ADDR_CH2_SETTLE, SCD_SETTLE_RESET);
    rd(SCD_ADDR_CH3_SETTLE, SCD_SETTLE_RESET);
    rd(SCD_ADDR_CH0_DIV, SCD_DIV_RESET);
    rd(SCD_ADDR_CH1_DIV, SCD_DIV_RESET);
    wr(8'h16, 16'hFFFF);
    rd(8'h16, 16'h0000);
    for (int c = 0; c < 2; c++) begin
      d = 16'($urandom());
      wr(c ? SCD_ADDR_CH3_SETTLE : SCD_ADDR_CH2_SETTLE, d);
      rd(c ? SCD_ADDR_CH3_SETTLE : SCD_ADDR_CH2_SETTLE, d);
    end
    $display("test registers done");
    for (int c = 0; c < 2; c++) begin
      // channel 0 fixed at two so the divide-by-two property is reached
      rdv = c ? 10'($urandom_range(8, 1)) : 10'h002;
      ndv = 4'($urandom_range(4, 2));
      wr(c ? SCD_ADDR_CH1_DIV : SCD_ADDR_CH0_DIV, {ndv, 2'b00, rdv});
      rd(c ? SCD_ADDR_CH1_DIV : SCD_ADDR_CH0_DIV, {ndv, 2'b00, rdv});
      repeat (100) @(posedge clk_i);
      chk("ref tick gap", 16'(rdv), gr[c][15:0]);
      chk("input tick gap", 16'(ndv * (c ? 7 : 5)), gi[c][15:0]);
    end
    $display("test dividers done");
    cnt = '{16'h0000, 16'h0001, 16'h0002, 16'($urandom_range(7, 3))};
    foreach (cnt[i]) for (int c = 0; c < 2; c++) settle(c, cnt[i]);
    $display("test settle done");
    for (int c = 0; c < 4; c++) abort(c % 2, c < 2);
    $display("test amplitude error done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(SCD_ADDR_CH3_SETTLE, SCD_SETTLE_RESET);
    repeat (2) @(posedge clk_i);
    $display("test second reset done");
    give_verdict();
  end
endmodule
